/* File: src/ring_shift_defines.vh */
/*
 shared constants for the ring shift register and its input fifo.
 assumes nothing beyond being included by bare name.
*/
`ifndef RING_SHIFT_DEFINES_VH
`define RING_SHIFT_DEFINES_VH
`define STAGE_COUNT      5
`define FIFO_WIDTH       2
`define FIFO_DEPTH       8
`define FIFO_PTR_W       3
`define STAGE_RESET_VAL  5'h00
`define MODE_SERIAL      2'h0
`define MODE_RECIRC      2'h1
`define MODE_TWISTED     2'h2
`define LVL_ZERO         1'b1
`define LVL_ONE          1'b0
`endif

/* File: src/bit_fifo.v */
/*
 holds no logic: the input fifo module sits in ring_shift_register.v.
 assumes nothing of its surroundings.
*/

/* File: src/ring_shift_register.v */
/*
 five-stage bidirectional ring shift register with serial input fifo.
 assumes steer, shift and force inputs are pins from another domain (in_valid and mode are not synced); levels use 1 = zero.
*/
`include "ring_shift_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ring_shift_register
(
    input  wire                    clk,
    input  wire                    rst_b,
    input  wire                    steer_in_true,
    input  wire                    steer_in_comp,
    input  wire                    in_valid,
    output wire                    in_ready,
    input  wire                    shift_fwd,
    input  wire                    shift_rev,
    input  wire [1:0]              mode,
    input  wire [`STAGE_COUNT-1:0] neg_force_diode_a,
    input  wire [`STAGE_COUNT-1:0] neg_force_diode_b,
    output reg  [`STAGE_COUNT-1:0] stage_out_true,
    output reg  [`STAGE_COUNT-1:0] stage_out_comp
);
    localparam N = `STAGE_COUNT;
    localparam SW = 2 * N + 4;

    // three-stage sync on every steer, shift and force pin (not in_valid or mode); change counts when stages 2 and 3 agree
    wire [SW-1:0] pin_raw;
    reg  [SW-1:0] sync1_r;
    reg  [SW-1:0] sync2_r;
    reg  [SW-1:0] sync3_r;
    reg  [SW-1:0] clean_r;
    reg  [SW-1:0] clean_nxt;
    reg  [SW-1:0] clean_d_r;
    assign pin_raw = {neg_force_diode_a, neg_force_diode_b,
                      steer_in_true, steer_in_comp, shift_fwd, shift_rev};

    genvar g;
    generate
        for (g = 0; g < SW; g = g + 1)
        begin : sync_bit
            always @*
            begin
                clean_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : clean_r[g];
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            sync1_r   <= {SW{1'b1}};
            sync2_r   <= {SW{1'b1}};
            sync3_r   <= {SW{1'b1}};
            clean_r   <= {SW{1'b1}};
            clean_d_r <= {SW{1'b1}};
        end
        else
        begin
            sync1_r   <= pin_raw;
            sync2_r   <= sync1_r;
            sync3_r   <= sync2_r;
            clean_r   <= clean_nxt;
            clean_d_r <= clean_r;
        end
    end

    wire [N-1:0] force_a   = clean_r[SW-1:N+4];
    wire [N-1:0] force_b_d = clean_d_r[N+3:4];
    wire [N-1:0] force_b   = clean_r[N+3:4];
    wire         st_true   = clean_r[3];
    wire         st_comp   = clean_r[2];
    wire         fwd_rise  = clean_r[1] & ~clean_d_r[1];
    wire         rev_rise  = clean_r[0] & ~clean_d_r[0];

    // serial pair enters the fifo; steer inputs held at reset-idle are not data
    wire       fifo_valid;
    wire [1:0] fifo_data;
    wire       take;
    bit_fifo
    #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .PTR_W (`FIFO_PTR_W)
    )
    u_fifo
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_data   ({st_true, st_comp}),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (take)
    );

    // a forward shift in serial mode is dropped unless a bit is queued
    wire fwd_go = fwd_rise && !rev_rise &&
                  ((mode != `MODE_SERIAL) || fifo_valid);
    wire rev_go = rev_rise && !fwd_rise;
    assign take = fwd_go && (mode == `MODE_SERIAL);

    // first- and last-stage gate pairs: steer 0 opens the path to that side (level 1 = zero)
    reg [1:0] head_gate;
    reg [1:0] tail_gate;
    always @*
    begin
        case (mode)
            `MODE_SERIAL:
                head_gate = {fifo_data[0], fifo_data[1]};
            `MODE_RECIRC:
                head_gate = {stage_out_comp[N-1], stage_out_true[N-1]};
            `MODE_TWISTED:
                head_gate = {stage_out_true[N-1], stage_out_comp[N-1]};
            default:
                head_gate = {`LVL_ZERO, `LVL_ZERO};
        endcase
        case (mode)
            `MODE_RECIRC:
                tail_gate = {stage_out_comp[0], stage_out_true[0]};
            `MODE_TWISTED:
                tail_gate = {stage_out_true[0], stage_out_comp[0]};
            default:
                tail_gate = {`LVL_ZERO, `LVL_ZERO};
        endcase
    end

    // gate pair to next value: true-side gate low sets stage to 1 (low level)
    function [1:0] steer;
        input [1:0] gate;
        input       cur_true;
        begin
            case (gate)
                2'b01:   steer = {`LVL_ZERO, `LVL_ONE};
                2'b10:   steer = {`LVL_ONE, `LVL_ZERO};
                default: steer = {cur_true, ~cur_true};
            endcase
        end
    endfunction

    reg [N-1:0] true_nxt;
    reg [N-1:0] comp_nxt;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : stage
            wire [1:0] fwd_gate;
            wire [1:0] rev_gate;
            wire [1:0] fwd_val;
            wire [1:0] rev_val;
            // a stage's comp output is the comp gate of its neighbour
            if (g == 0)
            begin : first
                assign fwd_gate = head_gate;
            end
            else
            begin : mid
                assign fwd_gate = {stage_out_comp[g-1], stage_out_true[g-1]};
            end
            if (g == N - 1)
            begin : last
                assign rev_gate = tail_gate;
            end
            else
            begin : mid_r
                assign rev_gate = {stage_out_comp[g+1], stage_out_true[g+1]};
            end
            assign fwd_val = steer(fwd_gate, stage_out_true[g]);
            assign rev_val = steer(rev_gate, stage_out_true[g]);
            always @*
            begin
                true_nxt[g] = stage_out_true[g];
                comp_nxt[g] = stage_out_comp[g];
                if (fwd_go)
                begin
                    {true_nxt[g], comp_nxt[g]} = fwd_val;
                end
                else if (rev_go)
                begin
                    {true_nxt[g], comp_nxt[g]} = rev_val;
                end
                // side a low forces 1; rising side b resets; both beat shifting
                if (force_a[g] == `LVL_ONE)
                begin
                    true_nxt[g] = `LVL_ONE;
                    comp_nxt[g] = `LVL_ZERO;
                end
                else if (force_b[g] & ~force_b_d[g])
                begin
                    true_nxt[g] = `LVL_ZERO;
                    comp_nxt[g] = `LVL_ONE;
                end
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            stage_out_true <= ~`STAGE_RESET_VAL;
            stage_out_comp <= `STAGE_RESET_VAL;
        end
        else
        begin
            stage_out_true <= true_nxt;
            stage_out_comp <= comp_nxt;
        end
    end
endmodule

module bit_fifo
#(
    parameter WIDTH = 2,
    parameter DEPTH = 8,
    parameter PTR_W = 3
)
(
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_r;
    reg [PTR_W-1:0] wr_ptr_nxt;
    reg [PTR_W-1:0] rd_ptr_r;
    reg [PTR_W-1:0] rd_ptr_nxt;
    reg [PTR_W:0]   count_r;
    reg [PTR_W:0]   count_nxt;
    wire            push;
    wire            pop;

    // full and empty come from the count, so the pointers may wrap freely
    assign in_ready  = (count_r != DEPTH);
    assign out_valid = (count_r != 0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @*
    begin
        out_data = mem[rd_ptr_r];
    end

    always @*
    begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push)
        begin
            wr_ptr_nxt = wr_ptr_r + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_nxt = rd_ptr_r + 1'b1;
        end
        if (push && !pop)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 1'b1;
        end
    end

    // storage is not reset: only words below the count are ever read
    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_r <= {PTR_W{1'b0}};
            rd_ptr_r <= {PTR_W{1'b0}};
            count_r  <= {(PTR_W+1){1'b0}};
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ring_shift_register_properties.sv */
/*
 port-level checks on the ring shift register.
 assumes a bind to ring_shift_register; pin edges land about 5 clocks late.
*/
`timescale 1ns/10ps
`default_nettype none
module ring_shift_register_properties
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       shift_fwd,
    input wire logic       shift_rev,
    input wire logic [1:0] mode,
    input wire logic [4:0] neg_force_diode_a,
    input wire logic [4:0] neg_force_diode_b,
    input wire logic [4:0] stage_out_true,
    input wire logic [4:0] stage_out_comp
);
    logic [4:0] snap_r;
    // pattern at the pulse edge, so later compares see the old content
    always @(posedge clk)
    begin
        if ($rose(shift_fwd) || $rose(shift_rev))
            snap_r <= stage_out_true;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RESET_LEVELS: assert property (disable iff (1'b0) !rst_b |=>
        stage_out_true == 5'h1f && stage_out_comp == 5'h00) else $error("bad reset levels");
    AST_COMPLEMENT: assert property (stage_out_comp == ~stage_out_true)
        else $error("outputs not complementary");
    AST_SET_HOLDS: assert property ($stable(neg_force_diode_a)[*8] |->
        (stage_out_true & ~neg_force_diode_a) == 5'h00) else $error("set not held");
    AST_IDLE_HOLD: assert property
        ($stable({shift_fwd, shift_rev, neg_force_diode_a, neg_force_diode_b})[*8]
        |-> $stable(stage_out_true)) else $error("stages moved while idle");
    AST_RECIRC_FWD: assert property (mode == 2'h1 && $rose(shift_fwd) && &neg_force_diode_a
        |-> ##[3:7] stage_out_true == {snap_r[3:0], snap_r[4]}) else $error("rotate lost");
    AST_RECIRC_REV: assert property (mode == 2'h1 && $rose(shift_rev) && &neg_force_diode_a
        |-> ##[3:7] stage_out_true == {snap_r[0], snap_r[4:1]}) else $error("reverse lost");
    AST_TWIST_FWD: assert property (mode == 2'h2 && $rose(shift_fwd) && &neg_force_diode_a
        |-> ##[3:7] stage_out_true == {snap_r[3:0], ~snap_r[4]}) else $error("twist wrong");
    AST_CLEAR_EDGE: assert property ($rose(neg_force_diode_b[0]) && neg_force_diode_a[0]
        |-> ##[3:7] stage_out_true[0]) else $error("clear edge missed");
endmodule
`default_nettype wire

/* File: verification/pulse_source.sv */
/*
 driving logic: steer pair, fifo push and one shift pulse per frame.
 assumes a one-cycle req; pulse lines stand low outside frames.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_source
(
    input  wire logic clk,
    input  wire logic req,
    input  wire logic dir,
    input  wire logic bit_val,
    input  wire logic push,
    output logic      busy,
    output logic      steer_in_true,
    output logic      steer_in_comp,
    output logic      in_valid,
    output logic      shift_fwd,
    output logic      shift_rev
);
    logic [4:0] cnt_r = 5'h00;
    logic       dir_r = 1'b0;
    logic       push_r = 1'b0;
    assign busy = cnt_r != 5'h00;
    initial {steer_in_true, steer_in_comp, in_valid, shift_fwd, shift_rev} = 5'h10;
    always @(posedge clk)
    begin
        if (req)
        begin
            // pair set 5 clocks before in_valid rises so the syncs settle
            steer_in_true <= ~bit_val;
            steer_in_comp <= bit_val;
            dir_r <= dir;
            push_r <= push;
            cnt_r <= 5'h01;
        end
        else if (busy)
            cnt_r <= (cnt_r == 5'h14) ? 5'h00 : cnt_r + 5'h01;
        in_valid <= push_r && cnt_r == 5'h05;
        shift_fwd <= !dir_r && cnt_r >= 5'h07 && cnt_r < 5'h0b;
        shift_rev <= dir_r && cnt_r >= 5'h07 && cnt_r < 5'h0b;
    end
endmodule
`default_nettype wire

/* File: verification/ring_shift_register_tb_top.sv */
/*
 self-checking bench for the ring shift register and its pulse source.
 assumes src on the include path; b holds the expected binary content.
*/
`timescale 1ns/10ps
`default_nettype none
module ring_shift_register_tb_top;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       req = 1'b0;
    logic       dir = 1'b0;
    logic       bit_val = 1'b0;
    logic       push = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [4:0] force_a = 5'h1f;
    logic [4:0] force_b = 5'h00;
    logic [4:0] b = 5'h00;
    wire        st_t, st_c, valid, ready, fwd, rev, busy;
    wire  [4:0] q_t, q_c;
    int         errors = 0;
    int         tests_run = 0;
    bit         q[$];
    always #12.5 clk = ~clk;
    pulse_source src (.clk(clk), .req(req), .dir(dir), .bit_val(bit_val), .push(push),
        .busy(busy), .steer_in_true(st_t), .steer_in_comp(st_c), .in_valid(valid),
        .shift_fwd(fwd), .shift_rev(rev));
    ring_shift_register dut (.clk(clk), .rst_b(rst_b), .steer_in_true(st_t),
        .steer_in_comp(st_c), .in_valid(valid), .in_ready(ready), .shift_fwd(fwd),
        .shift_rev(rev), .mode(mode), .neg_force_diode_a(force_a),
        .neg_force_diode_b(force_b), .stage_out_true(q_t), .stage_out_comp(q_c));
    task wrap_up;
        $display("%0d compares, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [4:0] e);
        tests_run++;
        if (q_t !== ~e || q_c !== e)
        begin
            errors++;
            $display("unexpected at %0t: stages %h want %h", $time, q_c, e);
        end
    endtask
    task chk_rdy(input logic e);
        tests_run++;
        if (ready !== e)
        begin
            errors++;
            $display("unexpected at %0t: in_ready %b", $time, ready);
        end
    endtask
    function automatic logic [4:0] nxt(input logic [4:0] v, input logic d, input logic f);
        case (mode)
            2'h0: nxt = d ? {v[4], v[4:1]} : {v[3:0], f};
            2'h1: nxt = d ? {v[0], v[4:1]} : {v[3:0], v[4]};
            2'h2: nxt = d ? {~v[0], v[4:1]} : {v[3:0], ~v[4]};
            default: nxt = d ? {v[4], v[4:1]} : {v[3:0], v[0]};
        endcase
    endfunction
    // one frame: optional push then a pulse; a full fifo drops the push
    task step(input logic d, input logic p, input logic v);
        @(posedge clk) #1;
        {req, dir, push, bit_val} = {1'b1, d, p, v};
        @(posedge clk) #1;
        req = 1'b0;
        for (int n = 0; n < 40 && busy; n++) @(posedge clk) #1;
        if (busy)
        begin
            errors++;
            $display("unexpected at %0t: frame hung", $time);
            wrap_up;
        end
        if (p && q.size() < 8) q.push_back(v);
        if (mode != 2'h0 || d) b = nxt(b, d, 1'b0);
        else if (q.size() != 0) b = nxt(b, d, q.pop_front());
        chk(b);
        chk_rdy(q.size() < 8);
    endtask
    initial
    begin
        void'($urandom(32'h0874));
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        chk(5'h00);
        repeat (5) @(posedge clk);
        for (int i = 0; i < 6; i++) step(i == 5, i < 5, 1'($urandom));
        step(1'b0, 1'b0, 1'b0);
        $display("serial test done");
        mode = 2'h1;
        for (int i = 0; i < 9; i++) step(1'($urandom), 1'b1, 1'($urandom));
        mode = 2'h0;
        for (int i = 0; i < 8; i++) step(1'b0, 1'b0, 1'b0);
        $display("fifo and recirculate test done");
        mode = 2'h2;
        for (int i = 0; i < 20; i++) step(i > 9, 1'b0, 1'b0);
        $display("twisted ring test done");
        mode = 2'h3;
        for (int i = 0; i < 4; i++) step(1'($urandom), 1'b0, 1'b0);
        $display("spare mode test done");
        force_a = ~5'($urandom);
        repeat (10) @(posedge clk);
        #1 b = b | ~force_a;
        chk(b);
        force_a = 5'h1f;
        repeat (8) @(posedge clk);
        #1 chk(b);
        force_b = 5'h1f;
        repeat (8) @(posedge clk);
        #1 chk(5'h00);
        $display("force test done");
        wrap_up;
    end
endmodule
bind ring_shift_register ring_shift_register_properties chk_u (.clk(clk), .rst_b(rst_b),
    .shift_fwd(shift_fwd), .shift_rev(shift_rev), .mode(mode),
    .neg_force_diode_a(neg_force_diode_a), .neg_force_diode_b(neg_force_diode_b),
    .stage_out_true(stage_out_true), .stage_out_comp(stage_out_comp));
`default_nettype wire
